// *** tb/cke_power_asserts.sv ***
// Assertions on the power state outputs of the clock-enable logic.
`timescale 1ns/1ps
module cke_power_asserts
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire cke_power_pkg::power_state_t power_state,
    input wire logic [cke_power_pkg::NUM_BANKS-1:0] bank_open,
    input wire logic device_idle,
    input wire logic odt_active,
    input wire logic internal_refresh
);
    import cke_power_pkg::*;
    localparam int TICK_MAX = SR_REFRESH_CYCLES + 1;
    int gap;
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    sequence sr_entry;
        power_state != ps_self_refresh ##1 power_state == ps_self_refresh;
    endsequence
    // A counter stands in for a long repetition, which the tools would unroll.
    always_ff @(posedge ref_clk)
    begin
        gap <= (sys_rst || power_state != ps_self_refresh || internal_refresh) ? 0 : gap + 1;
    end
    chk_sr_tick_gap: assert property (gap <= TICK_MAX)
        else $error("self refresh tick missing");
    chk_sr_odt_off: assert property (power_state == ps_self_refresh && $past(power_state) == ps_self_refresh |-> !odt_active)
        else $error("termination active in self refresh");
    chk_pd_no_tick: assert property (power_state inside {ps_active_pd, ps_precharge_pd} |-> !internal_refresh)
        else $error("refresh tick in power down");
    chk_idle_banks_closed: assert property (device_idle |-> $past(bank_open) == BANKS_CLOSED)
        else $error("idle with open bank");
    chk_idle_state: assert property (device_idle |-> $past(power_state) == ps_idle)
        else $error("idle outside idle state");
    chk_pd_banks_held: assert property (power_state == ps_active_pd && $past(power_state) == ps_active_pd |-> $stable(bank_open))
        else $error("bank mask changed in power down");
    chk_apd_entry_open: assert property (power_state == ps_active_pd && $past(power_state) != ps_active_pd |-> bank_open != BANKS_CLOSED)
        else $error("active power down with banks closed");
    chk_ppd_entry_closed: assert property (power_state == ps_precharge_pd && $past(power_state) != ps_precharge_pd |-> bank_open == BANKS_CLOSED)
        else $error("precharge power down with open bank");
    chk_sr_from_idle: assert property (sr_entry |-> $past(power_state) == ps_idle && bank_open == BANKS_CLOSED)
        else $error("self refresh entered from busy state");
endmodule // cke_power_asserts
bind cke_power_state cke_power_asserts cke_power_asserts_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .power_state(power_state), .bank_open(bank_open), .device_idle(device_idle), .odt_active(odt_active),
    .internal_refresh(internal_refresh));

// *** tb/ctrl_model.sv ***
// Behavioural memory controller making the memory clock, CKE and commands.
`timescale 1ns/1ps
module ctrl_model
(
    input wire logic ref_clk,
    input wire logic next_cke,
    input wire cke_power_pkg::cmd_pins_t next_cmd,
    output logic mem_ck,
    output logic cke,
    output cke_power_pkg::cmd_pins_t cmd_pins,
    output logic load_slot
);
    import cke_power_pkg::*;
    logic [3:0] phase = 4'h0;
    logic [6:0] noise = 7'h11;
    // The memory clock spans 16 system clocks. Pins change at its falling edge only, so a level spans each rise.
    always_ff @(posedge ref_clk)
    begin
        phase <= phase + 4'h1;
        mem_ck <= ~phase[3];
        load_slot <= (phase == 4'h6);
        noise <= {noise[5:0], noise[6] ^ noise[5]};
        if (phase == 4'h8)
        begin
            cke <= next_cke;
            cmd_pins <= next_cmd.cs_n ? cmd_pins_t'({1'b1, noise}) : next_cmd;
        end
    end
endmodule // ctrl_model

// *** tb/testbench.sv ***
// Self-checking bench for the clock-enable power state logic.
`timescale 1ns/1ps
module testbench;
    import cke_power_pkg::*;
    localparam logic [7:0] op_nop = 8'h70;
    localparam logic [7:0] op_des = 8'h80;
    localparam logic [7:0] op_act = 8'h30;
    localparam logic [7:0] op_pre_all = 8'h28;
    localparam logic [7:0] op_read = 8'h50;
    localparam logic [7:0] op_ref = 8'h10;
    logic ref_clk, sys_rst, next_cke, odt, mem_ck, cke, load_slot, device_idle, odt_active, internal_refresh;
    cmd_pins_t next_cmd, cmd_pins;
    power_state_t power_state;
    logic [7:0] bank_open, rnd;
    int n_mismatch = 0, checks = 0, cycles = 0, ticks;
    ctrl_model ctrl_model_i (.ref_clk(ref_clk), .next_cke(next_cke), .next_cmd(next_cmd), .mem_ck(mem_ck),
        .cke(cke), .cmd_pins(cmd_pins), .load_slot(load_slot));
    cke_power_state cke_power_state_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .mem_ck(mem_ck), .reset_n(1'b1),
        .cke(cke), .cmd_pins(cmd_pins), .odt(odt), .power_state(power_state), .bank_open(bank_open),
        .device_idle(device_idle), .odt_active(odt_active), .internal_refresh(internal_refresh));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [7:0] onehot(input logic [2:0] b);
        return 8'h01 << b;
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Two memory clock edges per call, the command and then a deselect; it returns between them.
    task automatic step(input logic k, input logic [7:0] c);
        @(posedge ref_clk iff load_slot);
        next_cke <= k;
        next_cmd <= c;
        repeat (2) @(posedge ref_clk);
        next_cmd <= op_des;
        repeat (16) @(posedge ref_clk);
    endtask
    task automatic give_verdict;
        if (n_mismatch == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // The ceiling leaves ample margin over the roughly 3100 cycles the sequence needs.
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            n_mismatch++;
            give_verdict();
        end
    end
    initial
    begin
        sys_rst = 1'b1;
        next_cke = 1'b1;
        next_cmd = op_des;
        odt = 1'b0;
        rnd = 8'h11;
        repeat (4) @(posedge ref_clk);
        sys_rst <= 1'b0;
        step(1'b1, op_nop);
        check(8'(power_state), 8'(ps_idle));
        repeat (3)
        begin
            rnd = lfsr(rnd);
            odt <= rnd[3];
            step(1'b1, op_act | rnd[2:0]);
            check(bank_open, onehot(rnd[2:0]));
            check(8'(odt_active), 8'(rnd[3]));
            step(1'b0, op_nop);
            check(8'(power_state), 8'(ps_active_pd));
            step(1'b0, op_pre_all);
            check(bank_open, onehot(rnd[2:0]));
            step(1'b1, op_nop);
            check(8'(power_state), 8'(ps_active));
            step(1'b1, op_read | {4'h0, rnd[6], rnd[2:0]});
            step(1'b0, op_nop);
            check(8'(power_state), rnd[6] ? 8'(ps_precharge_pd) : 8'(ps_active_pd));
            check(bank_open, rnd[6] ? 8'h00 : onehot(rnd[2:0]));
            repeat (5) step(1'b1, op_nop);
            step(1'b1, op_pre_all);
            check(bank_open, 8'h00);
            repeat (2) step(1'b1, op_nop);
            step(1'b0, op_nop);
            check(8'(power_state), 8'(ps_precharge_pd));
            repeat (5) step(1'b1, op_nop);
            check(8'(device_idle), 8'h01);
        end
        odt <= 1'b1;
        step(1'b0, op_ref);
        check(8'(power_state), 8'(ps_self_refresh));
        ticks = 0;
        repeat (900)
        begin
            @(posedge ref_clk);
            ticks += int'(internal_refresh === 1'b1);
        end
        check(8'(ticks), 8'h01);
        check(8'(odt_active), 8'h00);
        odt <= 1'b0;
        step(1'b1, op_nop);
        check(8'(power_state), 8'(ps_idle));
        check(8'(device_idle), 8'h00);
        repeat (5) step(1'b1, op_nop);
        check(8'(device_idle), 8'h01);
        odt <= 1'b1;
        step(1'b1, op_nop);
        check(8'(odt_active), 8'h01);
        give_verdict();
    end
endmodule // testbench

// *** verilog/cke_power_pkg.sv ***
// Shared types and constants for the clock-enable power state logic.
package cke_power_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int SR_REFRESH_INTERVAL_NS = 7800;
    localparam int SR_REFRESH_CYCLES = SR_REFRESH_INTERVAL_NS / CLK_PERIOD_NS;
    localparam int BURST_EDGES = 4;
    localparam int REFRESH_BUSY_EDGES = 8;
    localparam int SR_EXIT_EDGES = 8;
    localparam int PD_EXIT_EDGES = 3;
    localparam int NUM_BANKS = 8;
    localparam logic [NUM_BANKS-1:0] BANKS_CLOSED = 8'h00;

    // ****************************************
    // Types
    // ****************************************
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic a10;
        logic [2:0] ba;
    } cmd_pins_t;

    typedef enum logic [2:0] {
        cmd_nop,
        cmd_act,
        cmd_pre,
        cmd_read,
        cmd_write,
        cmd_refresh,
        cmd_other
    } cmd_t;

    typedef enum logic [2:0] {
        ps_idle,
        ps_active,
        ps_active_pd,
        ps_precharge_pd,
        ps_self_refresh
    } power_state_t;

endpackage

// *** verilog/cke_power_state.sv ***
// Clock-enable driven power state logic of the memory device.
`timescale 1ns/1ps
// How it works
// (RULE1) Each memory clock edge acts on previous CKE, current CKE and the registered command.
// (RULE2) Controller uses only listed state, CKE and command combinations.
// (RULE3) Termination never steers power states and is off in self refresh.
// (RULE4) Controller holds a new CKE level until just before its minimum pulse time.
// (RULE5) After self refresh exit the controller sends only no-ops until exit time.
// (RULE6) No reads or termination until the DLL-locked exit time after self refresh.
// (RULE7) Refresh with CKE falling from all banks idle enters self refresh.
// (RULE8) Controller sends only no-ops on power down entry and exit edges.
// (RULE9) Controller sends only no-ops on the self refresh exit edge.
// (RULE10) Controller never enters self refresh during a read or write.
// (RULE11) Power down performs no refresh of any kind.
// (RULE12) Command and address pins are ignored while CKE stays low in low power states.
// (RULE13) First write or leveling waits 512 clocks after self refresh exit.
// (RULE14) CKE falling during access or precharge picks power down type from banks after it.
// (RULE15) Idle means banks closed, no burst, CKE high and all timings met.
// (RULE16) CKE falling with no-op while refreshing or all idle enters precharge power down.
// (RULE17) CKE falling with no-op while banks open enters active power down.
// (RULE18) Controller drops CKE only after mode register delays are met.
// (RULE19) Self refresh keeps contents through an internally timed refresh.
module cke_power_state
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic mem_ck,
    input wire logic reset_n,
    input wire logic cke,
    input wire cke_power_pkg::cmd_pins_t cmd_pins,
    input wire logic odt,
    output cke_power_pkg::power_state_t power_state,
    output logic [cke_power_pkg::NUM_BANKS-1:0] bank_open,
    output logic device_idle,
    output logic odt_active,
    output logic internal_refresh
);
    import cke_power_pkg::*;

    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [3:0] meta_ctl;
    logic [3:0] sync_ctl;
    cmd_pins_t meta_cmd;
    cmd_pins_t sync_cmd;
    logic ck_last;
    always_ff @(posedge ref_clk)
    begin
        meta_ctl <= {mem_ck, reset_n, cke, odt};
        sync_ctl <= meta_ctl;
        meta_cmd <= cmd_pins;
        sync_cmd <= meta_cmd;
        ck_last <= sync_ctl[3];
    end

    logic ck_rise;
    logic rst_any;
    logic cke_now;
    assign ck_rise = sync_ctl[3] & ~ck_last;
    assign rst_any = sys_rst | ~sync_ctl[2];
    assign cke_now = sync_ctl[1];

    function automatic cmd_t decode_cmd(input cmd_pins_t p);
        if (p.cs_n)
            return cmd_nop;
        case ({p.ras_n, p.cas_n, p.we_n})
            3'h7: return cmd_nop;
            3'h3: return cmd_act;
            3'h2: return cmd_pre;
            3'h5: return cmd_read;
            3'h4: return cmd_write;
            3'h1: return cmd_refresh;
            default: return cmd_other;
        endcase
    endfunction

    cmd_t cmd;
    assign cmd = decode_cmd(sync_cmd);

    // ****************************************
    // Edge-to-edge CKE history
    // ****************************************
    logic cke_prev;
    always_ff @(posedge ref_clk)
    begin
        if (rst_any)
            cke_prev <= 1'b0;
        else if (ck_rise)
            cke_prev <= cke_now; // RULE1
    end

    // ****************************************
    // Busy timers, counted in memory clock edges
    // ****************************************
    logic [3:0] burst_cnt;
    logic [3:0] refresh_cnt;
    logic [3:0] exit_cnt;
    logic burst_autopre;
    logic [2:0] burst_bank;
    logic cmd_live;
    assign cmd_live = ck_rise & cke_prev & cke_now & (power_state == ps_idle || power_state == ps_active);

    always_ff @(posedge ref_clk)
    begin
        if (rst_any)
        begin
            burst_cnt <= 4'h0;
            burst_autopre <= 1'b0;
            burst_bank <= 3'h0;
        end
        else if (cmd_live && (cmd == cmd_read || cmd == cmd_write))
        begin
            burst_cnt <= 4'(BURST_EDGES);
            burst_autopre <= sync_cmd.a10;
            burst_bank <= sync_cmd.ba;
        end
        else if (ck_rise && burst_cnt != 4'h0)
            burst_cnt <= burst_cnt - 4'h1;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst_any)
            refresh_cnt <= 4'h0;
        else if (cmd_live && cmd == cmd_refresh)
            refresh_cnt <= 4'(REFRESH_BUSY_EDGES);
        else if (ck_rise && refresh_cnt != 4'h0)
            refresh_cnt <= refresh_cnt - 4'h1;
    end

    // ****************************************
    // Bank tracking
    // ****************************************
    logic cke_fall;
    logic [NUM_BANKS-1:0] pending_close;
    logic closed_after;
    assign cke_fall = ck_rise & cke_prev & ~cke_now;
    assign pending_close = (burst_autopre && burst_cnt != 4'h0) ? (NUM_BANKS'(1) << burst_bank) : BANKS_CLOSED;
    assign closed_after = ((bank_open & ~pending_close) == BANKS_CLOSED);

    // A pending auto-precharge is applied at power down entry, so the entry type matches the banks after the burst.
    always_ff @(posedge ref_clk)
    begin
        if (rst_any)
            bank_open <= BANKS_CLOSED;
        else if (cmd_live && cmd == cmd_act)
            bank_open[sync_cmd.ba] <= 1'b1;
        else if (cmd_live && cmd == cmd_pre)
        begin
            if (sync_cmd.a10)
                bank_open <= BANKS_CLOSED;
            else
                bank_open[sync_cmd.ba] <= 1'b0;
        end
        else if (cke_fall)
            bank_open <= bank_open & ~pending_close; // RULE14
        else if (ck_rise && burst_cnt == 4'h1 && burst_autopre)
            bank_open[burst_bank] <= 1'b0;
    end

    // ****************************************
    // Power state machine
    // ****************************************
    logic all_closed;
    logic cke_riseup;
    assign all_closed = (bank_open == BANKS_CLOSED);
    assign cke_riseup = ck_rise & ~cke_prev & cke_now;

    // The termination input is deliberately absent from this process.
    always_ff @(posedge ref_clk)
    begin
        if (rst_any)
        begin
            power_state <= ps_idle;
            exit_cnt <= 4'h0;
        end
        else
        begin
            if (ck_rise && exit_cnt != 4'h0)
                exit_cnt <= exit_cnt - 4'h1;
            case (power_state)
                ps_self_refresh:
                    if (cke_riseup) // RULE12
                    begin
                        power_state <= ps_idle;
                        exit_cnt <= 4'(SR_EXIT_EDGES);
                    end
                ps_active_pd, ps_precharge_pd:
                    if (cke_riseup) // RULE12
                    begin
                        power_state <= all_closed ? ps_idle : ps_active;
                        exit_cnt <= 4'(PD_EXIT_EDGES);
                    end
                ps_idle, ps_active:
                    if (cke_fall)
                    begin
                        if (cmd == cmd_refresh && all_closed && burst_cnt == 4'h0)
                            power_state <= ps_self_refresh; // RULE7
                        else if (refresh_cnt != 4'h0 || closed_after)
                            power_state <= ps_precharge_pd; // RULE16 RULE14
                        else
                            power_state <= ps_active_pd; // RULE17 RULE14
                    end
                    else if (ck_rise)
                        power_state <= all_closed ? ps_idle : ps_active;
                default:
                    power_state <= ps_idle;
            endcase
        end
    end

    // ****************************************
    // Status outputs
    // ****************************************
    always_ff @(posedge ref_clk)
    begin
        if (rst_any)
            device_idle <= 1'b0;
        else
            device_idle <= power_state == ps_idle && all_closed && burst_cnt == 4'h0
                && refresh_cnt == 4'h0 && cke_now && exit_cnt == 4'h0; // RULE15
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst_any)
            odt_active <= 1'b0;
        else
            odt_active <= sync_ctl[0] && power_state != ps_self_refresh; // RULE3
    end

    // Only self refresh runs this timer, so power down never refreshes.
    logic [9:0] sr_timer;
    always_ff @(posedge ref_clk)
    begin
        if (rst_any || power_state != ps_self_refresh) // RULE11
        begin
            sr_timer <= 10'h000;
            internal_refresh <= 1'b0;
        end
        else if (sr_timer == 10'(SR_REFRESH_CYCLES - 1))
        begin
            sr_timer <= 10'h000;
            internal_refresh <= 1'b1; // RULE19
        end
        else
        begin
            sr_timer <= sr_timer + 10'h001;
            internal_refresh <= 1'b0;
        end
    end

endmodule // cke_power_state
